/* File: logic/sfe_device.sv */
// sfe_device: flash command interpreter for erase, deep power-down and id reads
// assumes link pins are asynchronous to i_clk; the host clocks at most i_clk/16
//
// Implementation choices: register access over APB and the register offsets.
`default_nettype none
module sfe_device
  import sfe_pkg::*;
#(
  parameter int unsigned P_BLOCK_ERASE_CYC = (SFE_BLOCK_ERASE_NS + SFE_CLK_NS - 1) / SFE_CLK_NS,
  parameter int unsigned P_CHIP_ERASE_CYC = (SFE_CHIP_ERASE_NS + SFE_CLK_NS - 1) / SFE_CLK_NS,
  parameter logic [7:0] P_MAKER_ID = 8'h5A,  // arbitrary value
  parameter logic [7:0] P_DEVICE_ID = 8'h3C  // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  sfe_link_if.device link,
  input wire logic i_block_protect_bit0,
  input wire logic i_block_protect_bit1,
  input wire logic i_block_protect_bit2,
  input wire logic i_protect_complement,
  output var logic o_write_in_progress,
  output var logic o_write_enable_latch,
  output var logic o_deep_power_down,
  output var logic o_high_perf,
  output var logic o_erase_start,
  output var logic o_erase_chip,
  output var logic [SFE_BLOCK_W-1:0] o_erase_block
);
  logic [3:0] sync1, sync2, sync3; // three-stage pin synchronisers
  logic [3:0] pin;                 // filtered {cs_n, sclk, io1, io0}
  logic [3:0] pin_q;               // previous filtered levels for edges
  logic [5:0] bit_cnt;             // clocks in this frame, saturating
  logic [31:0] in_sr;              // opcode and address as shifted in
  logic [7:0] op;                  // opcode of this frame
  logic [15:0] out_sr;             // rotating id pattern
  logic rd_ok;                     // this frame may stream an id
  logic rd_dual;                   // two bits per clock
  sfe_timer_t tmr_kind;            // what the timer is timing
  logic [31:0] tmr_cnt;            // cycles left minus one
  logic write_enable_latch;                       // write enable latch
  logic dpd;                       // deep power-down mode
  logic hpm;                       // high performance mode
  logic rst_armed;                 // reset-enable seen in previous frame
  logic sclk_rise, sclk_fall, cs_rise, cs_fall;
  logic idle, awake, exact8, exact32, id_len;
  logic do_write_enable_cmd, do_be, do_ce, do_dp, do_rel, do_hpm_exit, do_hpm, do_rst;
  logic [2:0] bp;

  // protected region grows from the top block, complement inverts it
  function automatic logic blk_prot(input logic [SFE_BLOCK_W-1:0] blk,
                                    input logic [2:0] b, input logic cmp);
    logic [SFE_BLOCK_W:0] span;
    logic hit;
    span = (b == 3'h0) ? 7'h00 : 7'((8'h01 << b) >> 1);
    hit = ({1'b0, blk} >= (7'h40 - span));
    return hit ^ cmp;
  endfunction

  // sync chain; a change counts once stages two and three agree
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1 <= SFE_PIN_IDLE;
      sync2 <= SFE_PIN_IDLE;
      sync3 <= SFE_PIN_IDLE;
      pin <= SFE_PIN_IDLE;
      pin_q <= SFE_PIN_IDLE;
    end else begin
      sync1 <= {link.cs_n, link.sclk, link.io1, link.io0};
      sync2 <= sync1;
      sync3 <= sync2;
      pin <= (sync2 & sync3) | (pin & (sync2 ^ sync3));
      pin_q <= pin;
    end
  end

  assign cs_rise = pin[3] & ~pin_q[3];
  assign cs_fall = ~pin[3] & pin_q[3];
  assign sclk_rise = ~pin[3] & pin[2] & ~pin_q[2];
  assign sclk_fall = ~pin[3] & ~pin[2] & pin_q[2];
  assign bp = {i_block_protect_bit2, i_block_protect_bit1, i_block_protect_bit0};

  // frame decode, evaluated only at select rise
  always_comb begin
    idle = (tmr_kind == SFE_T_NONE); // busy cycles and release delays refuse all
    awake = !dpd;
    exact8 = (bit_cnt == SFE_OP_BITS);
    exact32 = (bit_cnt == SFE_ADDR_CMD_BITS);
    id_len = exact8 || (bit_cnt >= SFE_ADDR_CMD_BITS);
    do_write_enable_cmd = idle && awake && exact8 && (op == SFE_OP_WRITE_ENABLE);
    do_be = idle && awake && exact32 && (op == SFE_OP_BLOCK_ERASE) && write_enable_latch
      && !blk_prot(in_sr[SFE_BLOCK_LSB +: SFE_BLOCK_W], bp, i_protect_complement);
    do_ce = idle && awake && exact8 && write_enable_latch
      && ((op == SFE_OP_CHIP_ERASE_A) || (op == SFE_OP_CHIP_ERASE_B))
      && (((bp == 3'h0) && !i_protect_complement)
      || ((bp == 3'h7) && i_protect_complement));
    do_dp = idle && awake && exact8 && (op == SFE_OP_DEEP_POWER_DOWN);
    do_rel = idle && dpd && id_len && (op == SFE_OP_RELEASE_READ_ID);
    do_hpm_exit = idle && awake && id_len && (op == SFE_OP_RELEASE_READ_ID);
    do_hpm = idle && awake && exact32 && (op == SFE_OP_HIGH_PERF);
    do_rst = idle && rst_armed && exact8 && (op == SFE_OP_RESET);
  end

  // input shifter: bits taken on link clock rises while selected
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_cnt <= 6'h00;
      in_sr <= 32'h0000_0000;
      op <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt <= 6'h00; // fresh opcode on every select
    end else if (sclk_rise) begin
      in_sr <= {in_sr[30:0], pin[0]};
      if (bit_cnt != SFE_BITS_MAX)
        bit_cnt <= bit_cnt + 6'h01;
      if (bit_cnt == SFE_OP_BITS - 6'h01)
        op <= {in_sr[6:0], pin[0]};
    end
  end

  // id output: loaded after the 32nd clock, shifted on falling edges
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      out_sr <= 16'h0000;
      rd_ok <= 1'b0;
      rd_dual <= 1'b0;
      link.d_io0_o <= 1'b0;
      link.d_io0_oe <= 1'b0;
      link.d_io1_o <= 1'b0;
      link.d_io1_oe <= 1'b0;
    end else if (pin[3]) begin
      rd_ok <= 1'b0; // select high ends any stream and frees the lines
      link.d_io0_oe <= 1'b0;
      link.d_io1_oe <= 1'b0;
    end else if (sclk_rise && (bit_cnt == SFE_ADDR_CMD_BITS - 6'h01)) begin
      rd_dual <= (op == SFE_OP_READ_MAKER_ID_DUAL);
      if (op == SFE_OP_RELEASE_READ_ID) begin
        out_sr <= {P_DEVICE_ID, P_DEVICE_ID};
        rd_ok <= idle && (tmr_kind != SFE_T_BLOCK);
      end else begin
        out_sr <= {P_MAKER_ID, P_DEVICE_ID};
        rd_ok <= idle && awake && ((op == SFE_OP_READ_MAKER_ID)
          || (op == SFE_OP_READ_MAKER_ID_DUAL));
      end
    end else if (sclk_fall && rd_ok) begin
      link.d_io1_oe <= 1'b1;
      link.d_io1_o <= out_sr[15]; // msb first
      if (rd_dual) begin
        link.d_io0_oe <= 1'b1;
        link.d_io0_o <= out_sr[14];
        out_sr <= {out_sr[13:0], out_sr[15:14]};
      end else begin
        out_sr <= {out_sr[14:0], out_sr[15]}; // repeats until select rises
      end
    end
  end

  // self-timed cycles and release delays share one timer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tmr_kind <= SFE_T_NONE;
      tmr_cnt <= 32'h0000_0000;
    end else if (cs_rise && do_be) begin
      tmr_kind <= SFE_T_BLOCK;
      tmr_cnt <= 32'(P_BLOCK_ERASE_CYC - 1);
    end else if (cs_rise && do_ce) begin
      tmr_kind <= SFE_T_CHIP;
      tmr_cnt <= 32'(P_CHIP_ERASE_CYC - 1);
    end else if (cs_rise && do_dp) begin
      tmr_kind <= SFE_T_PD_ENTRY;
      tmr_cnt <= 32'(SFE_PD_ENTRY_CYC - 1);
    end else if (cs_rise && do_rel) begin
      tmr_kind <= SFE_T_RELEASE;
      tmr_cnt <= exact8 ? 32'(SFE_RELEASE_CYC - 1) : 32'(SFE_RELEASE_ID_CYC - 1);
    end else if (tmr_kind != SFE_T_NONE) begin
      if (tmr_cnt == 32'h0000_0000)
        tmr_kind <= SFE_T_NONE;
      else
        tmr_cnt <= tmr_cnt - 32'h0000_0001;
    end
  end

  // write-in-progress follows the erase timer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      o_write_in_progress <= 1'b0;
    else
      o_write_in_progress <= (tmr_kind == SFE_T_BLOCK) || (tmr_kind == SFE_T_CHIP);
  end

  // write enable latch: cleared as the erase starts, well before it ends
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      write_enable_latch <= 1'b0;
    else if (cs_rise && (do_write_enable_cmd))
      write_enable_latch <= 1'b1;
    else if (cs_rise && (do_be || do_ce || do_rst))
      write_enable_latch <= 1'b0;
  end

  // deep power-down entered only by its own command after the entry delay
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      dpd <= 1'b0;
    else if ((tmr_kind == SFE_T_PD_ENTRY) && (tmr_cnt == 32'h0000_0000))
      dpd <= 1'b1;
    else if (cs_rise && (do_rel || do_rst))
      dpd <= 1'b0;
  end

  // high performance mode and the two-frame reset arm
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hpm <= 1'b0;
      rst_armed <= 1'b0;
    end else if (cs_rise) begin
      rst_armed <= idle && exact8 && (op == SFE_OP_RESET_ENABLE);
      if (do_hpm)
        hpm <= 1'b1;
      else if (do_hpm_exit || do_dp || do_rel || do_rst)
        hpm <= 1'b0;
    end
  end

  // erase report to the array side, a one-cycle start pulse
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_erase_start <= 1'b0;
      o_erase_chip <= 1'b0;
      o_erase_block <= '0;
    end else begin
      o_erase_start <= cs_rise && (do_be || do_ce);
      if (cs_rise && (do_be || do_ce)) begin
        o_erase_chip <= do_ce;
        o_erase_block <= do_ce ? '0 : in_sr[SFE_BLOCK_LSB +: SFE_BLOCK_W]; // any address in block
      end
    end
  end

  assign o_write_enable_latch = write_enable_latch;
  assign o_deep_power_down = dpd;
  assign o_high_perf = hpm;
endmodule // sfe_device
`default_nettype wire

/* File: logic/sfe_pkg.sv */
// sfe_pkg: opcodes, bit counts, timings, host register map and state types
// assumes both ends run on one 100 MHz system clock
`default_nettype none
package sfe_pkg;
  // command opcodes
  localparam logic [7:0] SFE_OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] SFE_OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] SFE_OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] SFE_OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] SFE_OP_DEEP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] SFE_OP_RELEASE_READ_ID = 8'hAB;
  localparam logic [7:0] SFE_OP_READ_MAKER_ID = 8'h90;
  localparam logic [7:0] SFE_OP_READ_MAKER_ID_DUAL = 8'h92;
  localparam logic [7:0] SFE_OP_HIGH_PERF = 8'hA3;
  localparam logic [7:0] SFE_OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] SFE_OP_RESET = 8'h99;
  // frame lengths in link clocks
  localparam logic [5:0] SFE_OP_BITS = 6'h08;
  localparam logic [5:0] SFE_ADDR_CMD_BITS = 6'h20;
  localparam logic [5:0] SFE_BITS_MAX = 6'h3F;
  // 64KB block index inside the 24-bit address
  localparam int unsigned SFE_BLOCK_LSB = 16;
  localparam int unsigned SFE_BLOCK_W = 6;
  // idle level of {cs_n, sclk, io1, io0}
  localparam logic [3:0] SFE_PIN_IDLE = 4'hB;
  // times in ns and derived cycle counts
  localparam int unsigned SFE_CLK_NS = 10;
  localparam int unsigned SFE_BLOCK_ERASE_NS = 150000;
  localparam int unsigned SFE_CHIP_ERASE_NS = 500000;
  localparam int unsigned SFE_PD_ENTRY_NS = 3000;
  localparam int unsigned SFE_RELEASE_NS = 3000;
  localparam int unsigned SFE_RELEASE_ID_NS = 2000;
  localparam int unsigned SFE_PD_ENTRY_CYC = (SFE_PD_ENTRY_NS + SFE_CLK_NS - 1) / SFE_CLK_NS;
  localparam int unsigned SFE_RELEASE_CYC = (SFE_RELEASE_NS + SFE_CLK_NS - 1) / SFE_CLK_NS;
  localparam int unsigned SFE_RELEASE_ID_CYC = (SFE_RELEASE_ID_NS + SFE_CLK_NS - 1) / SFE_CLK_NS;
  // host register map, one 32-bit word each
  localparam logic [7:0] SFE_REG_CMD = 8'h00;
  localparam logic [7:0] SFE_REG_ADDR = 8'h04;
  localparam logic [7:0] SFE_REG_STATUS = 8'h08;
  localparam logic [7:0] SFE_REG_RXDATA = 8'h0C;
  localparam int unsigned SFE_CMD_NTX_LSB = 8;
  localparam int unsigned SFE_CMD_NRX_LSB = 16;
  localparam int unsigned SFE_CMD_DUAL_BIT = 24;
  localparam int unsigned SFE_CMD_START_BIT = 31;
  localparam int unsigned SFE_STATUS_BUSY_BIT = 0;
  // device self-timed activity
  typedef enum logic [2:0] {SFE_T_NONE, SFE_T_BLOCK, SFE_T_CHIP, SFE_T_PD_ENTRY,
    SFE_T_RELEASE} sfe_timer_t;
  // host frame engine
  typedef enum logic [1:0] {SFE_H_IDLE, SFE_H_SETUP, SFE_H_XFER, SFE_H_GAP} sfe_host_state_t;
endpackage
`default_nettype wire

/* File: logic/sfe_link_if.sv */
// sfe_link_if: the serial link between host and device
// io lines idle high when no end drives them (pull-up)
`default_nettype none
interface sfe_link_if;
  logic cs_n;      // select, active low, host driven
  logic sclk;      // link clock, host driven
  logic h_io0_o;   // host data onto io0
  logic h_io0_oe;  // host drives io0
  logic d_io0_o;   // device data onto io0 (dual read)
  logic d_io0_oe;
  logic d_io1_o;   // device data onto io1
  logic d_io1_oe;
  logic io0;       // resolved line levels
  logic io1;
  assign io0 = h_io0_oe ? h_io0_o : (d_io0_oe ? d_io0_o : 1'b1);
  assign io1 = d_io1_oe ? d_io1_o : 1'b1;
  modport host(output cs_n, output sclk, output h_io0_o, output h_io0_oe,
    input io0, input io1);
  modport device(input cs_n, input sclk, input io0, input io1,
    output d_io0_o, output d_io0_oe, output d_io1_o, output d_io1_oe);
endinterface
`default_nettype wire

/* File: logic/sfe_host.sv */
// sfe_host: apb-controlled serial flash command master
// assumes a zero-latency apb master on i_clk; drives select and link clock
`default_nettype none
module sfe_host
  import sfe_pkg::*;
#(
  parameter int unsigned P_HALF_CYC = 8,                // link clock half period
  parameter int unsigned P_CS_GAP_CYC = SFE_RELEASE_CYC // select high between frames
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output var logic [31:0] o_prdata,
  output var logic o_pready,
  output var logic o_pslverr,
  sfe_link_if.host link
);
  logic [31:0] cmd_reg;   // opcode, counts, dual flag
  logic [23:0] addr_reg;  // address bytes sent after the opcode
  logic [31:0] rx;        // last bytes received
  logic busy;             // frame or gap running
  sfe_host_state_t state;
  logic [7:0] div;        // half period divider
  logic tick;             // one-cycle enable per half period
  logic [8:0] clk_cnt;    // link clocks finished
  logic [8:0] tx_clks, tot_clks;
  logic [31:0] tx_sr;     // outgoing opcode and address
  logic [31:0] gap;       // select-high counter
  logic [1:0] s1, s2, s3, pin; // synchronised {io1, io0}
  logic access, wr_done, start;

  // three-stage sync on the returned data lines
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      s3 <= 2'h3;
      pin <= 2'h3;
    end else begin
      s1 <= {link.io1, link.io0};
      s2 <= s1;
      s3 <= s2;
      pin <= (s2 & s3) | (pin & (s2 ^ s3));
    end
  end

  assign access = i_psel && i_penable;
  assign wr_done = access && o_pready && i_pwrite;
  assign start = wr_done && (i_paddr == SFE_REG_CMD) && i_pwdata[SFE_CMD_START_BIT] && !busy;
  assign tick = (div == 8'(P_HALF_CYC - 1));

  // apb answer: one wait state so read data leaves a flop
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= access && !o_pready;
      o_pslverr <= access && !o_pready && !((i_paddr == SFE_REG_CMD)
        || (i_paddr == SFE_REG_ADDR) || (i_paddr == SFE_REG_STATUS)
        || (i_paddr == SFE_REG_RXDATA));
      unique case (i_paddr)
        SFE_REG_CMD: o_prdata <= cmd_reg;
        SFE_REG_ADDR: o_prdata <= {8'h00, addr_reg};
        SFE_REG_STATUS: o_prdata <= {31'h0000_0000, busy};
        SFE_REG_RXDATA: o_prdata <= rx;
        default: o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // register writes; command word refused while a frame runs
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_reg <= 32'h0000_0000;
      addr_reg <= 24'h00_0000;
    end else begin
      if (start)
        cmd_reg <= {1'b0, i_pwdata[30:0]};
      if (wr_done && (i_paddr == SFE_REG_ADDR) && !busy)
        addr_reg <= i_pwdata[23:0];
    end
  end

  // half period divider, restarted with each frame
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      div <= 8'h00;
    else if (start || tick)
      div <= 8'h00;
    else
      div <= div + 8'h01;
  end

  // frame engine: data changes on falling edges, io1 sampled there too
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= SFE_H_IDLE;
      busy <= 1'b0;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.h_io0_o <= 1'b0;
      link.h_io0_oe <= 1'b0;
      tx_sr <= 32'h0000_0000;
      clk_cnt <= 9'h000;
      tx_clks <= 9'h000;
      tot_clks <= 9'h000;
      rx <= 32'h0000_0000;
      gap <= 32'h0000_0000;
    end else begin
      unique case (state)
        SFE_H_IDLE: if (start) begin
          busy <= 1'b1;
          state <= SFE_H_SETUP;
          link.cs_n <= 1'b0;
          link.h_io0_oe <= 1'b1;
          link.h_io0_o <= i_pwdata[7];
          tx_sr <= {i_pwdata[7:0], addr_reg};
          clk_cnt <= 9'h000;
          tx_clks <= {2'h0, i_pwdata[SFE_CMD_NTX_LSB +: 4], 3'h0} + 9'h008;
          tot_clks <= {2'h0, i_pwdata[SFE_CMD_NTX_LSB +: 4], 3'h0} + 9'h008
            + (i_pwdata[SFE_CMD_DUAL_BIT] ? {3'h0, i_pwdata[SFE_CMD_NRX_LSB +: 4], 2'h0}
            : {2'h0, i_pwdata[SFE_CMD_NRX_LSB +: 4], 3'h0});
        end
        SFE_H_SETUP: if (tick)
          state <= SFE_H_XFER;
        SFE_H_XFER: if (tick) begin
          if (!link.sclk) begin
            link.sclk <= 1'b1;
          end else begin
            link.sclk <= 1'b0;
            clk_cnt <= clk_cnt + 9'h001;
            tx_sr <= {tx_sr[30:0], 1'b0};
            link.h_io0_o <= tx_sr[30];
            if (clk_cnt + 9'h001 >= tx_clks)
              link.h_io0_oe <= 1'b0; // free io0 for a dual answer
            if (clk_cnt >= tx_clks)
              rx <= cmd_reg[SFE_CMD_DUAL_BIT] ? {rx[29:0], pin} : {rx[30:0], pin[1]};
            if (clk_cnt + 9'h001 == tot_clks) begin
              state <= SFE_H_GAP; // select rises one half period after the last falling edge
              gap <= 32'(P_CS_GAP_CYC);
            end
          end
        end
        SFE_H_GAP: begin
          if (tick)
            link.cs_n <= 1'b1;
          if (link.cs_n) begin
            if (gap == 32'h0000_0000) begin
              state <= SFE_H_IDLE;
              busy <= 1'b0;
            end else begin
              gap <= gap - 32'h0000_0001;
            end
          end
        end
      endcase
    end
  end
endmodule // sfe_host
`default_nettype wire

/* File: tb/sfe_props.sv */
// sfe_props: checks on the link wires and on the device status outputs
// assumes both ends share i_clk; the testbench instantiates it beside the link
`default_nettype none
module sfe_props (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic h_io0_oe,
  input wire logic d_io0_oe,
  input wire logic d_io1_oe,
  input wire logic o_write_in_progress,
  input wire logic o_write_enable_latch,
  input wire logic o_deep_power_down,
  input wire logic o_erase_start
);
  timeunit 1ns;
  timeprecision 1ps;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // link clock rests low between frames
  property p_sclk_idle; cs_n && $past(cs_n) |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("link clock moves while deselected");
  // io0 never has two drivers at once
  property p_one_driver; h_io0_oe |-> !d_io0_oe; endproperty
  a_one_driver: assert property (p_one_driver) else $error("io0 driven by both ends");
  // device lets go of its lines soon after deselect
  property p_dev_quiet; cs_n [*8] |-> !d_io0_oe && !d_io1_oe; endproperty
  a_dev_quiet: assert property (p_dev_quiet) else $error("device drives while deselected");
  // busy follows the start of an erase on the next cycle
  property p_start_busy; o_erase_start |=> o_write_in_progress; endproperty
  a_start_busy: assert property (p_start_busy) else $error("erase started without busy");
  // latch drops by the cycle after the start
  property p_latch_drop; o_erase_start |-> ##[0:1] !o_write_enable_latch; endproperty
  a_latch_drop: assert property (p_latch_drop) else $error("latch kept after erase");
  // an erase only starts once the frame is closed
  property p_start_desel; o_erase_start |-> cs_n; endproperty
  a_start_desel: assert property (p_start_desel) else $error("erase started mid frame");
  // power-down never entered while busy or selected
  property p_pd_entry; $rose(o_deep_power_down) |-> cs_n && !o_write_in_progress; endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down entered while busy");
  // an erase needs the latch set beforehand
  property p_needs_latch; o_erase_start |-> $past(o_write_enable_latch); endproperty
  a_needs_latch: assert property (p_needs_latch) else $error("erase without latch");
endmodule // sfe_props
`default_nettype wire

/* File: tb/serial_flash_erase_powerdown_id_tb.sv */
// serial_flash_erase_powerdown_id_tb: apb drives the host, host talks to the device
// assumes host polls busy itself and keeps the select gap of the release delay
`default_nettype none
module serial_flash_erase_powerdown_id_tb import sfe_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BLK_CYC = 50;  // shortened erase times
  localparam int CHIP_CYC = 2000;  // long enough to overlap later frames
  localparam logic [7:0] MAKER_ID = 8'hA5;  // arbitrary value
  localparam logic [7:0] DEV_ID = 8'h17;  // arbitrary value
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, write_in_progress, write_enable_latch, pd, hp, es, ec, chip;
  logic [2:0] bp = 3'h0;  // protection setting
  logic cmp = 1'b0;
  logic [5:0] eb, blk;
  int n_fail = 0, comparisons = 0, n_erase = 0, wip_cyc = 0, cyc = 0;
  sfe_link_if link ();
  sfe_host u_sfe_host (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .link(link));
  sfe_device #(.P_BLOCK_ERASE_CYC(BLK_CYC), .P_CHIP_ERASE_CYC(CHIP_CYC), .P_MAKER_ID(MAKER_ID),
    .P_DEVICE_ID(DEV_ID)) u_sfe_device (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(link),
    .i_block_protect_bit0(bp[0]), .i_block_protect_bit1(bp[1]), .i_block_protect_bit2(bp[2]),
    .i_protect_complement(cmp), .o_write_in_progress(write_in_progress), .o_write_enable_latch(write_enable_latch),
    .o_deep_power_down(pd), .o_high_perf(hp), .o_erase_start(es), .o_erase_chip(ec),
    .o_erase_block(eb));
  sfe_props u_sfe_props (.i_clk(i_clk), .i_reset_n(i_reset_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .h_io0_oe(link.h_io0_oe), .d_io0_oe(link.d_io0_oe),
    .d_io1_oe(link.d_io1_oe), .o_write_in_progress(write_in_progress), .o_write_enable_latch(write_enable_latch),
    .o_deep_power_down(pd), .o_erase_start(es));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // erase monitor and watchdog; busy length is counted per erase
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (es === 1'b1) begin
      n_erase <= n_erase + 1;
      blk <= eb;
      chip <= ec;
      wip_cyc <= 0;
    end else if (write_in_progress === 1'b1) wip_cyc <= wip_cyc + 1;
    if (cyc == 100000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one link frame: start it, poll busy, then fetch what came back
  task automatic frame(input logic [7:0] op, input logic [3:0] ntx, nrx, input logic dual);
    apb(1'b1, SFE_REG_CMD, {1'b1, 6'h00, dual, 4'h0, nrx, 4'h0, ntx, op});
    repeat (4) @(posedge i_clk);
    rd = 32'h0000_0001;
    while (rd[SFE_STATUS_BUSY_BIT] !== 1'b0) apb(1'b0, SFE_REG_STATUS, 32'h0000_0000);
    apb(1'b0, SFE_REG_RXDATA, 32'h0000_0000);
  endtask
  task automatic do_reset();
    i_reset_n <= 1'b0;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
  endtask
  // latch set, then one erase frame under a protection setting {cmp, bp}
  task automatic erase(input logic [7:0] op, input logic [3:0] ntx, input logic [23:0] a,
      input logic [3:0] prot, input int n, input logic [5:0] b, input int c);
    int n0;
    n0 = n_erase;
    @(posedge i_clk);
    bp <= prot[2:0];
    cmp <= prot[3];
    frame(SFE_OP_WRITE_ENABLE, 4'h0, 4'h0, 1'b0);
    apb(1'b1, SFE_REG_ADDR, {8'h00, a});
    frame(op, ntx, 4'h0, 1'b0);
    for (int i = 0; i < 5000 && write_in_progress !== 1'b0; i++) @(posedge i_clk);
    chk("erase count", 32'(n0 + n), 32'(n_erase));
    if (n != 0) begin
      chk("block", 32'(b), 32'(blk));
      chk("chip flag", 32'(op != SFE_OP_BLOCK_ERASE), 32'(chip));
      chk("busy cycles", 32'(c), 32'(wip_cyc));
      chk("latch", 32'h0000_0000, 32'(write_enable_latch));
    end
  endtask
  // power-down and release/id frames sent while a chip erase runs
  task automatic s_busy();
    frame(SFE_OP_WRITE_ENABLE, 4'h0, 4'h0, 1'b0);
    frame(SFE_OP_CHIP_ERASE_A, 4'h0, 4'h0, 1'b0);
    frame(SFE_OP_DEEP_POWER_DOWN, 4'h0, 4'h0, 1'b0);
    frame(SFE_OP_RELEASE_READ_ID, 4'h3, 4'h1, 1'b0);
    chk("id while busy", 32'h0000_00FF, {24'h00_0000, rd[7:0]});
    for (int i = 0; i < 5000 && write_in_progress !== 1'b0; i++) @(posedge i_clk);
    repeat (SFE_PD_ENTRY_CYC + 20) @(posedge i_clk);
    chk("power down", 32'h0000_0000, 32'(pd));
    chk("busy cycles", 32'(CHIP_CYC), 32'(wip_cyc));
  endtask
  // high performance, power-down entry, commands refused, release, then reset
  task automatic s_pd();
    frame(SFE_OP_HIGH_PERF, 4'h3, 4'h0, 1'b0);
    chk("high perf", 32'h0000_0001, 32'(hp));
    frame(SFE_OP_RELEASE_READ_ID, 4'h0, 4'h0, 1'b0);
    chk("high perf", 32'h0000_0000, 32'(hp));
    frame(SFE_OP_DEEP_POWER_DOWN, 4'h0, 4'h0, 1'b0);
    repeat (20) @(posedge i_clk);
    chk("power down", 32'h0000_0001, 32'(pd));
    frame(SFE_OP_WRITE_ENABLE, 4'h0, 4'h0, 1'b0);
    chk("latch", 32'h0000_0000, 32'(write_enable_latch));
    frame(SFE_OP_RELEASE_READ_ID, 4'h0, 4'h0, 1'b0);
    chk("power down", 32'h0000_0000, 32'(pd));
    frame(SFE_OP_WRITE_ENABLE, 4'h0, 4'h0, 1'b0);
    chk("latch", 32'h0000_0001, 32'(write_enable_latch));
    frame(SFE_OP_DEEP_POWER_DOWN, 4'h0, 4'h0, 1'b0);
    frame(SFE_OP_RESET_ENABLE, 4'h0, 4'h0, 1'b0);
    frame(SFE_OP_RESET, 4'h0, 4'h0, 1'b0);
    chk("power down", 32'h0000_0000, 32'(pd));
    do_reset();
    chk("power down", 32'h0000_0000, 32'(pd));
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    do_reset();
    chk("power down", 32'h0000_0000, 32'(pd));
    apb(1'b1, 8'h10, 32'h1234_5678);
    chk("slave error", 32'h0000_0001, 32'(err));
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rd);
    erase(SFE_OP_BLOCK_ERASE, 4'h3, 24'h2A_BEEF, 4'h0, 1, 6'h2A, BLK_CYC);
    erase(SFE_OP_BLOCK_ERASE, 4'h3, 24'h3F_0001, 4'h1, 0, 6'h00, 0);
    erase(SFE_OP_BLOCK_ERASE, 4'h2, 24'h01_0000, 4'h0, 0, 6'h00, 0);
    erase(SFE_OP_BLOCK_ERASE, 4'h3, 24'h3F_0000, 4'h9, 1, 6'h3F, BLK_CYC);
    erase(SFE_OP_CHIP_ERASE_A, 4'h1, 24'h00_0000, 4'h0, 0, 6'h00, 0);
    erase(SFE_OP_CHIP_ERASE_B, 4'h0, 24'h00_0000, 4'h1, 0, 6'h00, 0);
    erase(SFE_OP_CHIP_ERASE_B, 4'h0, 24'h00_0000, 4'hF, 1, 6'h00, CHIP_CYC);
    erase(SFE_OP_BLOCK_ERASE, 4'h3, 24'h3F_FFFF, 4'h0, 1, 6'h3F, BLK_CYC);
    s_busy();
    s_pd();
    apb(1'b1, SFE_REG_ADDR, 32'h0000_0000);
    frame(SFE_OP_RELEASE_READ_ID, 4'h3, 4'h2, 1'b0);
    chk("device id", {16'h0000, DEV_ID, DEV_ID}, {16'h0000, rd[15:0]});
    frame(SFE_OP_READ_MAKER_ID, 4'h3, 4'h2, 1'b0);
    chk("maker id", {16'h0000, MAKER_ID, DEV_ID}, {16'h0000, rd[15:0]});
    frame(SFE_OP_READ_MAKER_ID_DUAL, 4'h3, 4'h4, 1'b1);
    chk("dual id", {MAKER_ID, DEV_ID, MAKER_ID, DEV_ID}, rd);
    final_report();
  end
endmodule // serial_flash_erase_powerdown_id_tb
`default_nettype wire
